// ===== design/aoicr_map.vh
`ifndef AOICR_MAP_VH
`define AOICR_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AOICR_OFF_SOFT_RESET  12'h000
`define AOICR_OFF_IF_CFG      12'h007
`define AOICR_OFF_PDN_CTRL    12'h008
`define AOICR_OFF_PDN_MASK    12'h00d
`define AOICR_OFF_FUSE_LOAD   12'h013
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define AOICR_RST_BIT         0
`define AOICR_MAP_MSB         7
`define AOICR_MAP_LSB         5
`define AOICR_OVR_BIT         3
`define AOICR_SEL_MSB         2
`define AOICR_SEL_LSB         0
`define AOICR_IF_CFG_MASK     8'hef
`define AOICR_MAP_KEEP_MASK   8'he0
`define AOICR_PDN_CTRL_MASK   8'h37
`define AOICR_PDN_MASK_MASK   8'h0e
`define AOICR_GLOBAL_POWERDOWN_BIT  0
`define AOICR_CHAN_B_POWERDOWN_BIT       1
`define AOICR_CHAN_A_POWERDOWN_BIT       2
`define AOICR_REFERENCE_AMP_POWERDOWN_BIT  4
`define AOICR_SAMPLE_CLOCK_BUFFER_POWERDOWN_BIT  5
`define AOICR_MASK_BGDIS_BIT  1
`define AOICR_MASK_REFAMP_BIT 2
`define AOICR_MASK_CLKBUF_BIT 3
`define AOICR_FUSE_LD_BIT     0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define AOICR_REG_RESET       8'h00
`define AOICR_MAP_2L_18_14    3'h1
`define AOICR_MAP_2L_16       3'h2
`define AOICR_MAP_1L          3'h3
`define AOICR_MAP_HALF        3'h4
`define AOICR_MODE_2L         3'h3
`define AOICR_MODE_1L         3'h4
`define AOICR_MODE_HALF       3'h5
`define AOICR_LANES_NONE      2'h0
`define AOICR_LANES_HALF      2'h1
`define AOICR_LANES_ONE       2'h2
`define AOICR_LANES_TWO       2'h3
`endif

// ===== design/aoicr_pdn_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "aoicr_map.vh"
module aoicr_pdn_decode (
  // Power-down control and mask
  input  wire [7:0] pdn_ctrl_i,
  input  wire [7:0] pdn_mask_i,
  // Block power-down controls
  output wire       chan_a_pdn_o,
  output wire       chan_b_pdn_o,
  output wire       clkbuf_pdn_o,
  output wire       refamp_pdn_o,
  output wire       bandgap_pdn_o
);
  wire glob = pdn_ctrl_i[`AOICR_GLOBAL_POWERDOWN_BIT];
  // Global down hits both channels always, other blocks only while their mask bit is clear
  assign chan_a_pdn_o  = pdn_ctrl_i[`AOICR_CHAN_A_POWERDOWN_BIT] | glob;
  assign chan_b_pdn_o  = pdn_ctrl_i[`AOICR_CHAN_B_POWERDOWN_BIT] | glob;
  assign clkbuf_pdn_o  = pdn_ctrl_i[`AOICR_SAMPLE_CLOCK_BUFFER_POWERDOWN_BIT]
                       | (glob & ~pdn_mask_i[`AOICR_MASK_CLKBUF_BIT]);
  assign refamp_pdn_o  = pdn_ctrl_i[`AOICR_REFERENCE_AMP_POWERDOWN_BIT]
                       | (glob & ~pdn_mask_i[`AOICR_MASK_REFAMP_BIT]);
  assign bandgap_pdn_o = glob & ~pdn_mask_i[`AOICR_MASK_BGDIS_BIT];
endmodule // aoicr_pdn_decode
`default_nettype wire

// ===== design/aoicr_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "aoicr_map.vh"
module aoicr_regs (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // Register port
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  input  wire [11:0] addr_i,
  input  wire [7:0]  wdata_i,
  output reg  [7:0]  rdata_o,
  // Fuse defaults
  input  wire [2:0]  fuse_mapping_i,
  input  wire [2:0]  fuse_mode_i,
  // Active configuration
  output reg  [2:0]  lane_bit_mapping_o,
  output reg  [1:0]  lane_count_o,
  output wire        fuse_load_pulse_o,
  output wire        soft_reset_pulse_o,
  // Power-down controls
  output wire        chan_a_pdn_o,
  output wire        chan_b_pdn_o,
  output wire        clkbuf_pdn_o,
  output wire        refamp_pdn_o,
  output wire        bandgap_pdn_o
);
  // ----------------------------------------
  // State and next values
  // ----------------------------------------
  reg  [7:0] if_cfg_reg;
  reg  [7:0] if_cfg_next;
  reg  [7:0] pdn_ctrl_reg;
  reg  [7:0] pdn_ctrl_next;
  reg  [7:0] pdn_mask_reg;
  reg  [7:0] pdn_mask_next;
  reg  [2:0] mapping_reg;
  reg  [2:0] mapping_next;
  reg  [2:0] fuse_mode_reg;
  reg  [2:0] fuse_mode_next;
  reg        fuse_pend_reg;
  reg        rst_pend_reg;
  reg        init_done_reg;
  reg  [1:0] lane_count_next;
  reg  [7:0] rdata_next;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Only listed mode codes give a lane count
  function [1:0] mode_lanes;
    input [2:0] code;
    begin
      case (code)
        `AOICR_MODE_2L:   mode_lanes = `AOICR_LANES_TWO;
        `AOICR_MODE_1L:   mode_lanes = `AOICR_LANES_ONE;
        `AOICR_MODE_HALF: mode_lanes = `AOICR_LANES_HALF;
        default:          mode_lanes = `AOICR_LANES_NONE;
      endcase
    end
  endfunction

  function mapping_valid;
    input [2:0] code;
    begin
      mapping_valid = (code == `AOICR_MAP_2L_18_14) || (code == `AOICR_MAP_2L_16)
                   || (code == `AOICR_MAP_1L) || (code == `AOICR_MAP_HALF);
    end
  endfunction

  // One decoder for every write strobe
  function wr_hit;
    input        en;
    input [11:0] addr;
    input [11:0] off;
    begin
      wr_hit = en && (addr == off);
    end
  endfunction

  wire [2:0] map_field = if_cfg_reg[`AOICR_MAP_MSB:`AOICR_MAP_LSB];
  wire [2:0] sel_field = if_cfg_reg[`AOICR_SEL_MSB:`AOICR_SEL_LSB];
  wire       wr_rst    = wr_hit(wr_en_i, addr_i, `AOICR_OFF_SOFT_RESET)
                         && wdata_i[`AOICR_RST_BIT];
  wire       wr_fuse   = wr_hit(wr_en_i, addr_i, `AOICR_OFF_FUSE_LOAD)
                         && wdata_i[`AOICR_FUSE_LD_BIT];

  assign soft_reset_pulse_o = rst_pend_reg;
  assign fuse_load_pulse_o  = fuse_pend_reg;

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  // Soft reset beats fuse load, which beats a write in that cycle
  always @* begin
    if_cfg_next   = if_cfg_reg;
    pdn_ctrl_next = pdn_ctrl_reg;
    pdn_mask_next = pdn_mask_reg;
    if (rst_pend_reg) begin
      if_cfg_next   = `AOICR_REG_RESET;
      pdn_ctrl_next = `AOICR_REG_RESET;
      pdn_mask_next = `AOICR_REG_RESET;
    end else if (fuse_pend_reg) begin
      // Mapper kept so the fuse load can apply it
      if_cfg_next   = if_cfg_reg & `AOICR_MAP_KEEP_MASK;
      pdn_ctrl_next = `AOICR_REG_RESET;
      pdn_mask_next = `AOICR_REG_RESET;
    end else begin
      // Reserved positions are dropped at write time
      if (wr_hit(wr_en_i, addr_i, `AOICR_OFF_IF_CFG))
        if_cfg_next = wdata_i & `AOICR_IF_CFG_MASK;
      if (wr_hit(wr_en_i, addr_i, `AOICR_OFF_PDN_CTRL))
        pdn_ctrl_next = wdata_i & `AOICR_PDN_CTRL_MASK;
      if (wr_hit(wr_en_i, addr_i, `AOICR_OFF_PDN_MASK))
        pdn_mask_next = wdata_i & `AOICR_PDN_MASK_MASK;
    end
  end

  // ----------------------------------------
  // Fuse-backed next values
  // ----------------------------------------
  always @* begin
    mapping_next   = mapping_reg;
    fuse_mode_next = fuse_mode_reg;
    if (!init_done_reg) begin
      // Fuse straps captured on the first edge after reset
      mapping_next   = fuse_mapping_i;
      fuse_mode_next = fuse_mode_i;
    end else if (fuse_pend_reg) begin
      // Written mapper wins; unused code falls back to fuses
      if (mapping_valid(map_field))
        mapping_next = map_field;
      else
        mapping_next = fuse_mapping_i;
      fuse_mode_next = fuse_mode_i;
    end
  end

  // Mode override acts at once, no fuse load needed
  always @* begin
    if (if_cfg_reg[`AOICR_OVR_BIT])
      lane_count_next = mode_lanes(sel_field);
    else
      lane_count_next = mode_lanes(fuse_mode_reg);
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Fields read zero until written, not the fuse value
  always @* begin
    rdata_next = rdata_o;
    if (rd_en_i) begin
      case (addr_i)
        `AOICR_OFF_IF_CFG:   rdata_next = if_cfg_reg;
        `AOICR_OFF_PDN_CTRL: rdata_next = pdn_ctrl_reg;
        `AOICR_OFF_PDN_MASK: rdata_next = pdn_mask_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      if_cfg_reg    <= `AOICR_REG_RESET;
      pdn_ctrl_reg  <= `AOICR_REG_RESET;
      pdn_mask_reg  <= `AOICR_REG_RESET;
      rst_pend_reg  <= 1'b0;
      fuse_pend_reg <= 1'b0;
    end else begin
      if_cfg_reg    <= if_cfg_next;
      pdn_ctrl_reg  <= pdn_ctrl_next;
      pdn_mask_reg  <= pdn_mask_next;
      rst_pend_reg  <= wr_rst;
      fuse_pend_reg <= wr_fuse;
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mapping_reg   <= 3'h0;
      fuse_mode_reg <= 3'h0;
      init_done_reg <= 1'b0;
    end else begin
      mapping_reg   <= mapping_next;
      fuse_mode_reg <= fuse_mode_next;
      init_done_reg <= 1'b1;
    end
  end

  // Outputs from flops so the lane logic sees clean levels
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lane_bit_mapping_o <= 3'h0;
      lane_count_o       <= `AOICR_LANES_NONE;
      rdata_o            <= 8'h00;
    end else begin
      lane_bit_mapping_o <= mapping_reg;
      lane_count_o       <= lane_count_next;
      rdata_o            <= rdata_next;
    end
  end

  // ----------------------------------------
  // Power-down decode
  // ----------------------------------------
  aoicr_pdn_decode u_pdn (
    .pdn_ctrl_i    (pdn_ctrl_reg),
    .pdn_mask_i    (pdn_mask_reg),
    .chan_a_pdn_o  (chan_a_pdn_o),
    .chan_b_pdn_o  (chan_b_pdn_o),
    .clkbuf_pdn_o  (clkbuf_pdn_o),
    .refamp_pdn_o  (refamp_pdn_o),
    .bandgap_pdn_o (bandgap_pdn_o)
  );
endmodule // aoicr_regs
`default_nettype wire

// ===== testbench/adc_output_if_config_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module adc_output_if_config_regs_tb_top;
  logic clk_i, rstn_i, wr_en, rd_en, chan_a, chan_b, clkbuf, refamp, bgap;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, d, m;
  logic [2:0]  fmap, fmode, map, cur, i;
  logic [1:0]  lanes;
  int          miscompares, n_tests, cycles, k;
  logic [7:0]  exp_q[$];
  aoicr_host host (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  aoicr_regs uut (.clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .fuse_mapping_i(fmap), .fuse_mode_i(fmode),
    .lane_bit_mapping_o(map), .lane_count_o(lanes), .fuse_load_pulse_o(), .soft_reset_pulse_o(),
    .chan_a_pdn_o(chan_a), .chan_b_pdn_o(chan_b), .clkbuf_pdn_o(clkbuf), .refamp_pdn_o(refamp),
    .bandgap_pdn_o(bgap));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // Read data is registered on the edge that samples rd_en and checked 2 ns later
  always @(posedge clk_i) begin
    if (rd_en === 1'b1) begin
      #2;
      chk("rdata", rdata, exp_q.pop_front());
    end
  end
  initial begin
    rstn_i = 1'b0;
    void'($urandom(85007));
    fmap = 3'h1 + 3'($urandom % 4);
    fmode = 3'h3 + 3'($urandom % 3);
    repeat (3) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("fuse map", map, fmap);
    chk("fuse lanes", lanes, 8'h6 - fmode);
    rd(12'h007, 8'h00);
    rd(12'h008, 8'h00);
    $display("test defaults done");
    cur = fmap;
    for (i = 3'h1; i <= 3'h4; i++) begin
      host.access(1'b1, 12'h007, {i, 5'h00});
      chk("map held", map, cur);
      host.access(1'b1, 12'h013, 8'h01);
      repeat (3) @(posedge clk_i);
      cur = i;
      #1 chk("map", map, cur);
      rd(12'h007, {i, 5'h00});
    end
    host.access(1'b1, 12'h007, 8'he0);
    host.access(1'b1, 12'h013, 8'h01);
    repeat (3) @(posedge clk_i);
    cur = fmap;
    #1 chk("map fallback", map, cur);
    $display("test mapper done");
    for (i = 3'h3; i <= 3'h5; i++)
      for (k = 1; k >= 0; k--) begin
        host.access(1'b1, 12'h007, {cur, 1'b0, k[0], i});
        repeat (3) @(posedge clk_i);
        #1 chk("lanes", lanes, k ? 8'h6 - i : 8'h6 - fmode);
      end
    host.access(1'b1, 12'h007, 8'hff);
    rd(12'h007, 8'hef);
    chk("unused mode", lanes, 8'h00);
    $display("test mode done");
    repeat (4) begin
      d = 8'($urandom);
      m = 8'($urandom);
      host.access(1'b1, 12'h00d, m);
      host.access(1'b1, 12'h008, d);
      chk("chan a", chan_a, d[2] | d[0]);
      chk("chan b", chan_b, d[1] | d[0]);
      chk("clk buf", clkbuf, d[5] | (d[0] & ~m[3]));
      chk("ref amp", refamp, d[4] | (d[0] & ~m[2]));
      chk("bandgap", bgap, d[0] & ~m[1]);
      rd(12'h008, d & 8'h37);
      rd(12'h00d, m & 8'h0e);
    end
    rd(12'h00a, 8'h00);
    host.access(1'b1, 12'h000, 8'h01);
    rd(12'h000, 8'h00);
    rd(12'h008, 8'h00);
    rd(12'h007, 8'h00);
    rd(12'h00d, 8'h00);
    chk("lanes after reset", lanes, 8'h6 - fmode);
    repeat (2) @(posedge clk_i);
    $display("test power down and soft reset done");
    report_and_stop();
  end
endmodule // adc_output_if_config_regs_tb_top
`default_nettype wire

// ===== testbench/aoicr_host.sv
`timescale 1ns/1ns
`default_nettype none
module aoicr_host (
  // Clock
  input  wire logic        clk_i,
  // Register port drive
  output var  logic        wr_en_o,
  output var  logic        rd_en_o,
  output var  logic [11:0] addr_o,
  output var  logic [7:0]  wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 12'h000;
    wdata_o = 8'h00;
  end
  // One-cycle strobe; data inverted after release so stale values never match
  task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_en_o = wr;
    rd_en_o = !wr;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = ~d;
  endtask
endmodule // aoicr_host
`default_nettype wire

// ===== testbench/aoicr_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module aoicr_regs_chk (
  // Clock, reset and register port
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  // Observed outputs
  input wire logic [7:0]  rdata_o,
  input wire logic [2:0]  lane_bit_mapping_o,
  input wire logic [1:0]  lane_count_o,
  input wire logic        fuse_load_pulse_o,
  input wire logic        soft_reset_pulse_o,
  input wire logic        chan_a_pdn_o,
  input wire logic        chan_b_pdn_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [2:0] since_ld_reg;
  // Mapping may only move shortly after reset or a fuse load
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) since_ld_reg <= 3'h0;
    else if (fuse_load_pulse_o) since_ld_reg <= 3'h0;
    else if (since_ld_reg != 3'h7) since_ld_reg <= since_ld_reg + 3'h1;
  sequence wr_at(a, d); wr_en_i && addr_i == a && d; endsequence
  sequence rst_pulse; soft_reset_pulse_o ##1 !soft_reset_pulse_o; endsequence
  a_soft_rst_pulse: assert property (wr_at(12'h000, wdata_i[0]) |=> rst_pulse)
    else $error("soft reset pulse missing");
  a_pdn_cleared: assert property (soft_reset_pulse_o |=> !chan_a_pdn_o && !chan_b_pdn_o)
    else $error("power down kept over soft reset");
  a_fuse_pulse: assert property (wr_at(12'h013, wdata_i[0]) |=> fuse_load_pulse_o)
    else $error("fuse load pulse missing");
  a_map_hold: assert property ($changed(lane_bit_mapping_o) |-> since_ld_reg < 3'h5)
    else $error("mapping moved without fuse load");
  a_chan_pdn: assert property (wr_at(12'h008, 1'b1) |=>
    {chan_a_pdn_o, chan_b_pdn_o} == ($past(wdata_i[2:1]) | {2{$past(wdata_i[0])}}))
    else $error("channel power down wrong");
  a_mode_apply: assert property (wr_at(12'h007, wdata_i[3:0] == 4'hc) |->
    ##[1:3] lane_count_o == 2'h2) else $error("mode override not applied");
  a_rd_zero: assert property (rd_en_i && addr_i != 12'h007 && addr_i != 12'h008
    && addr_i != 12'h00d |=> rdata_o == 8'h00) else $error("read not zero");
  a_if_rsvd: assert property (wr_at(12'h007, 1'b1)
    ##2 rd_en_i && addr_i == 12'h007 |=> !rdata_o[4]) else $error("reserved bit read back");
  a_pdn_rsvd: assert property (rd_en_i && addr_i == 12'h008 |=> !(|(rdata_o & 8'hc8)))
    else $error("reserved power down bits set");
endmodule // aoicr_regs_chk
bind aoicr_regs aoicr_regs_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .lane_bit_mapping_o(lane_bit_mapping_o), .lane_count_o(lane_count_o),
  .fuse_load_pulse_o(fuse_load_pulse_o), .soft_reset_pulse_o(soft_reset_pulse_o),
  .chan_a_pdn_o(chan_a_pdn_o), .chan_b_pdn_o(chan_b_pdn_o));
`default_nettype wire
